// *** logic/rfac_pkg.sv ***
// Purpose: Constants for automatic carrier field control
// Assumes: 10 MHz ref_clk
// Notes:   Offsets are byte addresses on the plain register port
package rfac_pkg;
	localparam logic [15:0] RFAC_ADDR_AUTO     = 16'h6305;
	localparam logic [15:0] RFAC_ADDR_SEL      = 16'h6306;
	localparam logic [15:0] RFAC_ADDR_CTRL     = 16'h6304;
	localparam logic [15:0] RFAC_ADDR_STAT     = 16'h6307;
	localparam logic [7:0]  RFAC_AUTO_RST      = 8'h00;
	localparam logic [7:0]  RFAC_SEL_RST       = 8'h10;
	localparam logic [7:0]  RFAC_CTRL_RST      = 8'h00;
	localparam int          RFAC_B_AUTO_OFF    = 7;
	localparam int          RFAC_B_FULL_ASK    = 6;
	localparam int          RFAC_B_WAKE        = 5;
	localparam int          RFAC_B_CA          = 3;
	localparam int          RFAC_B_INIT        = 2;
	localparam int          RFAC_B_DRV2        = 1;
	localparam int          RFAC_B_DRV1        = 0;
	localparam int          RFAC_B_CHECK       = 2;
	localparam int          RFAC_CLK_HZ        = 10_000_000;
	localparam int          RFAC_ACTIVE_DELAY_TIME_NS       = 20_000;
	localparam int          RFAC_INITIAL_DELAY_TIME_NS       = 40_000;
	localparam int          RFAC_ACTIVE_DELAY_TIME_CYC      = (RFAC_ACTIVE_DELAY_TIME_NS / 100 > 0) ? RFAC_ACTIVE_DELAY_TIME_NS / 100 : 1;
	localparam int          RFAC_INITIAL_DELAY_TIME_CYC      = (RFAC_INITIAL_DELAY_TIME_NS / 100 > 0) ? RFAC_INITIAL_DELAY_TIME_NS / 100 : 1;
	localparam logic [1:0]  RFAC_DRV_TRI       = 2'h0;
	localparam logic [1:0]  RFAC_DRV_CODER     = 2'h1;
	localparam logic [1:0]  RFAC_DRV_EXT       = 2'h2;
	localparam logic [1:0]  RFAC_DRV_HIGH      = 2'h3;
endpackage : rfac_pkg

// *** logic/rfac_top.sv ***
// Purpose: Automatic carrier field control and transmitter source select
// Assumes: One clock ref_clk, asynchronous active-low reset
// Notes:   All state in one struct; ctrl at 0x6304, status at 0x6307
// Operation
// RULE_01: Carrier off after last bit when enabled; an active or initial delay ending in that same cycle still sets it
// RULE_02: Force full ASK overrides conductance setting
// RULE_03: Field wakes power-down when enabled
// RULE_04: Collision avoid enables internal slot choice
// RULE_05: Initial field-on starts, clears at carrier-on
// RULE_06: Initial field-on stays set if carrier on
// RULE_07: Software selects drivers before initial request
// RULE_08: Auto-enable sets carrier after active delay
// RULE_09: Initial turn-on needs field-free initial delay
// RULE_10: Auto register resets zero, mixed access
// RULE_11: Source-select field layout, bit four resets one
// RULE_12: Source-select fully read and writable
// RULE_13: Driver source encodes tri, coder, ext, high
// RULE_14: Carrier enable drives modulated antenna output
// RULE_15: Field-check blocks auto-set under external field
// RULE_16: Delays counted in cycles, field input synchronised
//
// Local design decision: the strobed register port.
module rfac_top
	import rfac_pkg::*;
#(
	parameter int ACTIVE_DELAY_TIME_CYC = RFAC_ACTIVE_DELAY_TIME_CYC,
	parameter int INITIAL_DELAY_TIME_CYC = RFAC_INITIAL_DELAY_TIME_CYC,
	parameter int SLOT_W   = 2
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// Register port
	input  wire logic [15:0]       reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	// Field and transmit status
	input  wire logic              ext_field_pin,
	input  wire logic              tx_last_bit,
	input  wire logic              cu_power_down,
	// Antenna and control outputs
	output logic                   drv1_carrier_on,
	output logic                   drv2_carrier_on,
	output logic                   force_full_ask,
	output logic                   cu_wake,
	output logic                   collision_avoid_on,
	output logic      [SLOT_W-1:0] ca_slot_n,
	output logic      [1:0]        load_modulation_source,
	output logic      [1:0]        antenna_driver_source,
	output logic      [3:0]        aux_output_source,
	output logic                   drv1_out_en,
	output logic                   drv2_out_en
);

	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		RFAC_IDLE = 3'b001,
		RFAC_WAIT = 3'b010,
		RFAC_INIT = 3'b100
	} rfac_state_t;

	typedef struct packed {
		logic [2:0]        sync;
		logic              field;
		logic              field_prev;
		rfac_state_t       st;
		logic [15:0]       cnt;
		logic [7:0]        auto_r;
		logic [7:0]        sel_r;
		logic [7:0]        ctrl_r;
		logic [SLOT_W-1:0] lfsr;
		logic [SLOT_W-1:0] slot;
		logic [7:0]        rdata;
		logic              wake;
		logic              d1_en;
		logic              d2_en;
	} rfac_regs_t;

	rfac_regs_t s_q;
	rfac_regs_t s_d;
	logic       auto_any;
	logic       carrier_any;
	logic       blocked;

	assign auto_any    = s_q.auto_r[RFAC_B_DRV1] | s_q.auto_r[RFAC_B_DRV2];
	assign carrier_any = s_q.ctrl_r[0] | s_q.ctrl_r[1];
	assign blocked     = s_q.ctrl_r[RFAC_B_CHECK] & s_q.field; // RULE_15

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d       = s_q;
		s_d.rdata = 8'h00;
		// Field input from another domain: change counts once 2nd and 3rd agree
		s_d.sync = {s_q.sync[1:0], ext_field_pin}; // RULE_16
		if (s_q.sync[2] == s_q.sync[1]) begin
			s_d.field = s_q.sync[2];
		end
		s_d.field_prev = s_q.field;
		// Free-running LFSR gives the random slot
		s_d.lfsr = {s_q.lfsr[SLOT_W-2:0], ~^s_q.lfsr};
		if (reg_wr) begin
			unique case (reg_addr)
				RFAC_ADDR_AUTO: begin
					s_d.auto_r = {reg_wdata[7:5], 1'b0, reg_wdata[3:0]}; // RULE_10
					if (reg_wdata[RFAC_B_CA] && !s_q.auto_r[RFAC_B_CA]) begin
						s_d.slot = s_q.lfsr; // RULE_04
					end
					if (!reg_wdata[RFAC_B_INIT]) begin
						s_d.auto_r[RFAC_B_INIT] = s_q.auto_r[RFAC_B_INIT];
					end
				end
				RFAC_ADDR_SEL:  s_d.sel_r  = reg_wdata; // RULE_12
				RFAC_ADDR_CTRL: begin
					s_d.ctrl_r = reg_wdata;
					// Field check refuses new carrier bits while a field is sensed and a driver is auto-enabled
					if (reg_wdata[RFAC_B_CHECK] && s_q.field && auto_any) begin
						s_d.ctrl_r[1:0] = reg_wdata[1:0] & s_q.ctrl_r[1:0]; // RULE_15
					end
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				RFAC_ADDR_AUTO: s_d.rdata = {s_q.auto_r[7:5], 1'b0, s_q.auto_r[3], 1'b0,
				                             s_q.auto_r[1:0]}; // RULE_10
				RFAC_ADDR_SEL:  s_d.rdata = s_q.sel_r; // RULE_12
				RFAC_ADDR_CTRL: s_d.rdata = {s_q.ctrl_r[7:3], 1'b0, s_q.ctrl_r[1:0]};
				RFAC_ADDR_STAT: s_d.rdata = {5'h00, s_q.auto_r[RFAC_B_INIT], s_q.field,
				                             s_q.wake};
				default:        s_d.rdata = 8'h00;
			endcase
		end
		// Initial request with carrier already on: bit stays set
		s_d.wake = s_q.auto_r[RFAC_B_WAKE] & cu_power_down & s_q.field; // RULE_03
		if (s_q.auto_r[RFAC_B_AUTO_OFF] && tx_last_bit) begin
			s_d.ctrl_r[1:0] = 2'b00; // RULE_01
		end
		unique case (s_q.st)
			RFAC_IDLE: begin
				s_d.cnt = 16'h0000;
				if (s_q.auto_r[RFAC_B_INIT] && auto_any && !carrier_any) begin
					s_d.st = RFAC_INIT;
				end else if (auto_any && s_q.field_prev && !s_q.field) begin
					s_d.st = RFAC_WAIT; // RULE_08
				end
			end
			RFAC_WAIT: begin
				s_d.cnt = s_q.cnt + 16'h0001;
				if (s_q.field) begin
					s_d.st = RFAC_IDLE;
				end else if (s_q.cnt >= 16'(ACTIVE_DELAY_TIME_CYC - 1)) begin
					s_d.st = RFAC_IDLE;
					if (!blocked) begin
						s_d.ctrl_r[0] = s_q.auto_r[RFAC_B_DRV1]; // RULE_08
						s_d.ctrl_r[1] = s_q.auto_r[RFAC_B_DRV2];
					end
				end
			end
			RFAC_INIT: begin
				s_d.cnt = s_q.cnt + 16'h0001;
				if (s_q.field) begin
					s_d.cnt = 16'h0000; // RULE_09
				end else if (s_q.cnt >= 16'(INITIAL_DELAY_TIME_CYC - 1)) begin
					s_d.st = RFAC_IDLE;
					if (!blocked) begin
						s_d.ctrl_r[0]           = s_q.auto_r[RFAC_B_DRV1]; // RULE_09
						s_d.ctrl_r[1]           = s_q.auto_r[RFAC_B_DRV2];
						s_d.auto_r[RFAC_B_INIT] = 1'b0; // RULE_05
					end
				end
				if (!auto_any) begin
					s_d.st = RFAC_IDLE;
				end
			end
			default: s_d.st = RFAC_IDLE;
		endcase
		// Driver enables follow carrier bits unless source is tristate
		s_d.d1_en = s_d.ctrl_r[0] & (s_d.sel_r[5:4] != RFAC_DRV_TRI); // RULE_13 RULE_14
		s_d.d2_en = s_d.ctrl_r[1] & (s_d.sel_r[5:4] != RFAC_DRV_TRI);
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q        <= '0;
			s_q.st     <= RFAC_IDLE;
			s_q.auto_r <= RFAC_AUTO_RST; // RULE_10
			s_q.sel_r  <= RFAC_SEL_RST; // RULE_11
			s_q.ctrl_r <= RFAC_CTRL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata              = s_q.rdata;
	assign drv1_carrier_on        = s_q.ctrl_r[0]; // RULE_14
	assign drv2_carrier_on        = s_q.ctrl_r[1];
	assign force_full_ask         = s_q.auto_r[RFAC_B_FULL_ASK]; // RULE_02
	assign cu_wake                = s_q.wake;
	assign collision_avoid_on     = s_q.auto_r[RFAC_B_CA]; // RULE_04
	assign ca_slot_n              = s_q.slot;
	assign load_modulation_source = s_q.sel_r[7:6]; // RULE_11
	assign antenna_driver_source  = s_q.sel_r[5:4];
	assign aux_output_source      = s_q.sel_r[3:0];
	assign drv1_out_en            = s_q.d1_en;
	assign drv2_out_en            = s_q.d2_en;

	////////////////////////////////////////////////////////////////////////////
	property p_auto_off;
		@(posedge ref_clk) disable iff (!arst_n)
		(s_q.auto_r[RFAC_B_AUTO_OFF] && tx_last_bit && s_q.st == RFAC_IDLE)
			|=> !drv1_carrier_on && !drv2_carrier_on;
	endproperty
	a_auto_off: assert property (p_auto_off) else $error("carrier left on"); // RULE_01

	property p_ask;
		@(posedge ref_clk) disable iff (!arst_n)
		force_full_ask == s_q.auto_r[RFAC_B_FULL_ASK];
	endproperty
	a_ask: assert property (p_ask) else $error("ask mismatch"); // RULE_02

	property p_wake;
		@(posedge ref_clk) disable iff (!arst_n)
		(s_q.auto_r[RFAC_B_WAKE] && cu_power_down && s_q.field) |=> cu_wake;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake"); // RULE_03

	property p_init_keep;
		@(posedge ref_clk) disable iff (!arst_n)
		(s_q.st == RFAC_IDLE && carrier_any && s_q.auto_r[RFAC_B_INIT] && !reg_wr
		 && !tx_last_bit) |=> s_q.auto_r[RFAC_B_INIT];
	endproperty
	a_init_keep: assert property (p_init_keep) else $error("init cleared"); // RULE_06

	property p_no_field_on;
		@(posedge ref_clk) disable iff (!arst_n)
		(s_q.st != RFAC_IDLE && s_q.field && s_q.ctrl_r[1:0] == 2'b00 && !reg_wr)
			|=> s_q.ctrl_r[1:0] == 2'b00;
	endproperty
	a_no_field_on: assert property (p_no_field_on) else $error("on in field"); // RULE_09

	property p_block;
		@(posedge ref_clk) disable iff (!arst_n)
		(blocked && !reg_wr && s_q.ctrl_r[1:0] == 2'b00) |=> s_q.ctrl_r[1:0] == 2'b00;
	endproperty
	a_block: assert property (p_block) else $error("check bypassed"); // RULE_15

	property p_rsvd;
		@(posedge ref_clk) disable iff (!arst_n)
		(reg_rd && reg_addr == RFAC_ADDR_AUTO) |=> reg_rdata[4] == 1'b0 && reg_rdata[2] == 1'b0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("rsvd read"); // RULE_10

	property p_sel_rw;
		@(posedge ref_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == RFAC_ADDR_SEL) ##1 (reg_rd && reg_addr == RFAC_ADDR_SEL && !reg_wr)
			|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_sel_rw: assert property (p_sel_rw) else $error("sel readback"); // RULE_12

	property p_wait_len;
		@(posedge ref_clk) disable iff (!arst_n)
		(s_q.st == RFAC_IDLE && $past(s_q.st) == RFAC_WAIT && !$past(s_q.field))
			|-> $past(s_q.cnt) == 16'(ACTIVE_DELAY_TIME_CYC - 1);
	endproperty
	a_wait_len: assert property (p_wait_len) else $error("active delay"); // RULE_16

	property p_init_clear;
		@(posedge ref_clk) disable iff (!arst_n)
		(s_q.st == RFAC_INIT && !s_q.field && s_q.cnt >= 16'(INITIAL_DELAY_TIME_CYC - 1) && auto_any
		 && !blocked) |=> !s_q.auto_r[RFAC_B_INIT];
	endproperty
	a_init_clear: assert property (p_init_clear) else $error("init kept"); // RULE_05

	property p_init_carrier;
		@(posedge ref_clk) disable iff (!arst_n)
		(s_q.st == RFAC_INIT && !s_q.field && s_q.cnt >= 16'(INITIAL_DELAY_TIME_CYC - 1) && !blocked
		 && s_q.auto_r[RFAC_B_DRV1]) |=> drv1_carrier_on;
	endproperty
	a_init_carrier: assert property (p_init_carrier) else $error("init no carrier"); // RULE_09

	property p_init_len;
		@(posedge ref_clk) disable iff (!arst_n)
		(s_q.st == RFAC_IDLE && $past(s_q.st) == RFAC_INIT && $past(auto_any))
			|-> $past(s_q.cnt) == 16'(INITIAL_DELAY_TIME_CYC - 1);
	endproperty
	a_init_len: assert property (p_init_len) else $error("initial delay"); // RULE_09

	property p_wait_set;
		@(posedge ref_clk) disable iff (!arst_n)
		(s_q.st == RFAC_WAIT && !s_q.field && s_q.cnt >= 16'(ACTIVE_DELAY_TIME_CYC - 1) && !blocked
		 && s_q.auto_r[RFAC_B_DRV2]) |=> drv2_carrier_on;
	endproperty
	a_wait_set: assert property (p_wait_set) else $error("wait no carrier"); // RULE_08

	property p_wait_enter;
		@(posedge ref_clk) disable iff (!arst_n)
		(s_q.st == RFAC_IDLE && auto_any && s_q.field_prev && !s_q.field
		 && !(s_q.auto_r[RFAC_B_INIT] && !carrier_any)) |=> s_q.st == RFAC_WAIT;
	endproperty
	a_wait_enter: assert property (p_wait_enter) else $error("no wait"); // RULE_08

	property p_rdata_idle;
		@(posedge ref_clk) disable iff (!arst_n)
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("rdata stale"); // RULE_10

	property p_rsvd_wr;
		@(posedge ref_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == RFAC_ADDR_AUTO) |=> !s_q.auto_r[4];
	endproperty
	a_rsvd_wr: assert property (p_rsvd_wr) else $error("rsvd stored"); // RULE_10

	property p_src_fields;
		@(posedge ref_clk) disable iff (!arst_n)
		{load_modulation_source, antenna_driver_source, aux_output_source} == s_q.sel_r;
	endproperty
	a_src_fields: assert property (p_src_fields) else $error("source fields"); // RULE_11

	property p_out_en1;
		@(posedge ref_clk) disable iff (!arst_n)
		drv1_out_en == (drv1_carrier_on && antenna_driver_source != RFAC_DRV_TRI);
	endproperty
	a_out_en1: assert property (p_out_en1) else $error("drv1 enable"); // RULE_13

	property p_out_en2;
		@(posedge ref_clk) disable iff (!arst_n)
		drv2_out_en == (drv2_carrier_on && antenna_driver_source != RFAC_DRV_TRI);
	endproperty
	a_out_en2: assert property (p_out_en2) else $error("drv2 enable"); // RULE_14

	property p_ca_slot;
		@(posedge ref_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == RFAC_ADDR_AUTO && reg_wdata[RFAC_B_CA] && !collision_avoid_on)
			|=> ca_slot_n == $past(s_q.lfsr);
	endproperty
	a_ca_slot: assert property (p_ca_slot) else $error("slot not latched"); // RULE_04

	property p_sync;
		@(posedge ref_clk) disable iff (!arst_n)
		(s_q.sync[2] == s_q.sync[1]) |=> s_q.field == $past(s_q.sync[2]);
	endproperty
	a_sync: assert property (p_sync) else $error("field sync"); // RULE_16

	property p_block_wr;
		@(posedge ref_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == RFAC_ADDR_CTRL && reg_wdata[RFAC_B_CHECK] && s_q.field
		 && auto_any && s_q.ctrl_r[1:0] == 2'b00 && s_q.st == RFAC_IDLE)
			|=> s_q.ctrl_r[1:0] == 2'b00;
	endproperty
	a_block_wr: assert property (p_block_wr) else $error("write in field"); // RULE_15

endmodule : rfac_top

// *** tb/rfac_peer.sv ***
// Purpose: Remote contactless device sharing the carrier field
// Assumes: Bench commands when the remote field is up
// Notes:   Field level only, no data frames
module rfac_peer (
	// Clock
	input  wire logic ref_clk,
	// Command from bench
	input  wire logic field_cmd,
	// Field seen by the level detector
	output logic      ext_field_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial ext_field_pin = 1'b0;
	// Registered so the pin never moves on the sampling edge
	always @(posedge ref_clk) begin
		ext_field_pin <= #20 field_cmd;
	end
endmodule : rfac_peer

// *** tb/rfac_top_tb.sv ***
// Purpose: Register and carrier sequencing tests
// Assumes: Short delay parameters, 10 MHz ref_clk
// Notes:   Waits are bounded; a spent bound fails the run
module rfac_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rfac_pkg::*;
	logic ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic tx_last_bit = 1'b0, cu_power_down = 1'b0, field_cmd = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, d;
	logic [1:0]  ca_slot_n, load_modulation_source, antenna_driver_source;
	logic [3:0]  aux_output_source;
	logic drv1_carrier_on, drv2_carrier_on, force_full_ask, cu_wake, collision_avoid_on;
	logic drv1_out_en, drv2_out_en, ext_field_pin;
	int fail_count = 0;
	int samples_checked = 0;
	int n;
	rfac_top #(.ACTIVE_DELAY_TIME_CYC(4), .INITIAL_DELAY_TIME_CYC(8), .SLOT_W(2)) DUT (.ref_clk, .arst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_field_pin, .tx_last_bit,
		.cu_power_down, .drv1_carrier_on, .drv2_carrier_on, .force_full_ask, .cu_wake,
		.collision_avoid_on, .ca_slot_n, .load_modulation_source, .antenna_driver_source,
		.aux_output_source, .drv1_out_en, .drv2_out_en);
	rfac_peer peer (.ref_clk, .field_cmd, .ext_field_pin);
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		if (fail_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd
	// Bounded wait for a carrier pattern
	task automatic wait_car(input logic [1:0] e, output int k);
		k = 0;
		while ({drv2_carrier_on, drv1_carrier_on} !== e && k < 100) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		if (k >= 100) begin
			fail_count++;
			end_of_test();
		end
	endtask : wait_car
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(RFAC_ADDR_AUTO, d);
		check(d, 8'h00);
		rd(RFAC_ADDR_SEL, d);
		check(d, 8'h10);
		check({6'h0, antenna_driver_source}, 8'h01);
		wr(RFAC_ADDR_AUTO, 8'h10);
		rd(RFAC_ADDR_AUTO, d);
		check(d, 8'h00);
		wr(RFAC_ADDR_SEL, 8'ha5);
		rd(RFAC_ADDR_SEL, d);
		check(d, 8'ha5);
		check({load_modulation_source, antenna_driver_source, aux_output_source}, 8'ha5);
		wr(RFAC_ADDR_SEL, 8'h10);
		wr(16'h6300, 8'hff);
		rd(16'h6300, d);
		check(d, 8'h00);
		wr(RFAC_ADDR_AUTO, 8'h03);
		wr(RFAC_ADDR_AUTO, 8'h07);
		wait_car(2'b11, n);
		check(8'(n >= 6), 8'h01);
		rd(RFAC_ADDR_STAT, d);
		check({7'h0, d[2]}, 8'h00);
		check({6'h0, drv2_out_en, drv1_out_en}, 8'h03);
		// Auto-off on the last bit
		wr(RFAC_ADDR_AUTO, 8'h83);
		tx_last_bit <= 1'b1;
		@(posedge ref_clk);
		tx_last_bit <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check({6'h0, drv2_carrier_on, drv1_carrier_on}, 8'h00);
		// Remote field up with the field check on
		wr(16'h6304, 8'h04);
		field_cmd <= 1'b1;
		repeat (30) @(posedge ref_clk);
		check({6'h0, drv2_carrier_on, drv1_carrier_on}, 8'h00);
		wr(16'h6304, 8'h07);
		repeat (2) @(posedge ref_clk);
		check({6'h0, drv2_carrier_on, drv1_carrier_on}, 8'h00);
		field_cmd <= 1'b0;
		wait_car(2'b11, n);
		check(8'(n >= 6), 8'h01);
		wr(RFAC_ADDR_AUTO, 8'h6b);
		cu_power_down <= 1'b1;
		field_cmd <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check({5'h0, force_full_ask, collision_avoid_on, cu_wake}, 8'h07);
		check({7'h0, ^ca_slot_n === 1'bx}, 8'h00);
		field_cmd <= 1'b0;
		cu_power_down <= 1'b0;
		repeat (10) @(posedge ref_clk);
		// Carrier already on, so the request stays pending
		wr(RFAC_ADDR_AUTO, 8'h07);
		repeat (12) @(posedge ref_clk);
		rd(RFAC_ADDR_STAT, d);
		check({7'h0, d[2]}, 8'h01);
		end_of_test();
	end
endmodule : rfac_top_tb
